/* bench/gpc_io_ctrl_monitor.sv */
module gpc_io_ctrl_monitor #(
  parameter int B_WIDTH = 8
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic DATA_WR_I,
  input wire logic DATA_RD_I,
  input wire logic IO_WR_I,
  input wire logic IO_RD_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic [7:0] RDATA_O,
  input wire logic HIT_O,
  input wire logic [B_WIDTH-1:0] PB_PULLUP_O,
  input wire logic SLEEP_EXEC_I,
  input wire logic IRQ_BLOCK_O,
  input wire logic BROWNOUT_SLEEP_OFF_O,
  input wire logic DETECTOR_OFF_IN_SLEEP_O
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ctrl_wr;
  logic ctrl_rd;
  logic no_wr;
  assign ctrl_wr = (DATA_WR_I && ADDR_I == 8'h55) || (IO_WR_I && ADDR_I[5:0] == 6'h35);
  assign ctrl_rd = (DATA_RD_I && ADDR_I == 8'h55) || (IO_RD_I && ADDR_I[5:0] == 6'h35);
  assign no_wr = !DATA_WR_I && !IO_WR_I;
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RST_N_I);
  property p_ctrl_hit;
    ctrl_rd |=> HIT_O;
  endproperty
  a_ctrl_hit: assert property (p_ctrl_hit) else $error("control read gave no hit");
  property p_unmapped;
    DATA_RD_I && ADDR_I == 8'h29 |=> !HIT_O && RDATA_O == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
  property p_readback;
    DATA_WR_I && ADDR_I == 8'h24 ##1 no_wr ##1 DATA_RD_I && ADDR_I == 8'h24 && no_wr
      |=> RDATA_O == $past(WDATA_I, 3);
  endproperty
  a_readback: assert property (p_readback) else $error("direction readback differs");
  property p_pullup_off;
    ctrl_wr && WDATA_I[4] |-> ##2 PB_PULLUP_O == '0;
  endproperty
  a_pullup_off: assert property (p_pullup_off) else $error("pull-up left on after global off");
  property p_unlock_blocks;
    ctrl_wr && WDATA_I[0] |=> IRQ_BLOCK_O;
  endproperty
  a_unlock_blocks: assert property (p_unlock_blocks) else $error("unlock did not block");
  property p_sleep_pulse;
    $rose(BROWNOUT_SLEEP_OFF_O) |-> BROWNOUT_SLEEP_OFF_O [*3] ##1 !BROWNOUT_SLEEP_OFF_O;
  endproperty
  a_sleep_pulse: assert property (p_sleep_pulse) else $error("sleep-off not three cycles");
  property p_sleep_arm;
    ctrl_wr && WDATA_I[6:5] == 2'b11 ##[1:4] ctrl_wr && WDATA_I[6:5] == 2'b10 |-> ##[3:4] BROWNOUT_SLEEP_OFF_O;
  endproperty
  a_sleep_arm: assert property (p_sleep_arm) else $error("armed sleep-off not active");
  property p_detector_cause;
    $rose(DETECTOR_OFF_IN_SLEEP_O) |-> $past(SLEEP_EXEC_I) && $past(BROWNOUT_SLEEP_OFF_O);
  endproperty
  a_detector_cause: assert property (p_detector_cause) else $error("detector off without cause");
endmodule : gpc_io_ctrl_monitor

bind gpc_io_ctrl gpc_io_ctrl_monitor #(.B_WIDTH(B_WIDTH)) u_mon (
  .CLK_SYS_I(CLK_SYS_I),
  .RST_N_I(RST_N_I),
  .DATA_WR_I(DATA_WR_I),
  .DATA_RD_I(DATA_RD_I),
  .IO_WR_I(IO_WR_I),
  .IO_RD_I(IO_RD_I),
  .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I),
  .RDATA_O(RDATA_O),
  .HIT_O(HIT_O),
  .PB_PULLUP_O(PB_PULLUP_O),
  .SLEEP_EXEC_I(SLEEP_EXEC_I),
  .IRQ_BLOCK_O(IRQ_BLOCK_O),
  .BROWNOUT_SLEEP_OFF_O(BROWNOUT_SLEEP_OFF_O),
  .DETECTOR_OFF_IN_SLEEP_O(DETECTOR_OFF_IN_SLEEP_O)
);

/* bench/gpc_pad_model.sv */
module gpc_pad_model #(
  parameter int W = 8
) (
  input wire logic [W-1:0] out_i,
  input wire logic [W-1:0] oe_i,
  input wire logic [W-1:0] pullup_i,
  input wire logic [W-1:0] ext_i,
  output logic [W-1:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Undriven, unpulled pins take the weak outside level
  assign pin_o = (oe_i & out_i) | (~oe_i & pullup_i) | (~oe_i & ~pullup_i & ext_i);
endmodule : gpc_pad_model

/* bench/tb_io_port_and_mcu_control_regs.sv */
module tb_io_port_and_mcu_control_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, dwr = 1'b0, drd = 1'b0, iwr = 1'b0, ird = 1'b0;
  logic slp = 1'b0, boot = 1'b0, alck = 1'b0, blck = 1'b0, idone = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, ext_b = 8'h81, ext_d = 8'h5A;
  logic [6:0] ext_c = 7'h2B;
  logic hit, vec, blk, bso, bis;
  logic [7:0] b_out, b_oe, b_pu, b_pin, d_out, d_oe, d_pu, d_pin;
  logic [6:0] c_out, c_oe, c_pu, c_pin;
  logic [7:0] regs [0:6] = '{8'h24, 8'h25, 8'h27, 8'h28, 8'h2A, 8'h2B, 8'h55};
  int err_count = 0;
  int tests_run = 0;
  int n;
  always #20 clk = ~clk;
  gpc_pad_model #(.W(8)) u_pad_b (.out_i(b_out), .oe_i(b_oe), .pullup_i(b_pu), .ext_i(ext_b), .pin_o(b_pin));
  gpc_pad_model #(.W(7)) u_pad_c (.out_i(c_out), .oe_i(c_oe), .pullup_i(c_pu), .ext_i(ext_c), .pin_o(c_pin));
  gpc_pad_model #(.W(8)) u_pad_d (.out_i(d_out), .oe_i(d_oe), .pullup_i(d_pu), .ext_i(ext_d), .pin_o(d_pin));
  gpc_io_ctrl uut (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .DATA_WR_I(dwr), .DATA_RD_I(drd), .IO_WR_I(iwr), .IO_RD_I(ird),
    .ADDR_I(addr), .WDATA_I(wdata), .RDATA_O(rdata), .HIT_O(hit),
    .PB_PIN_I(b_pin), .PB_OUT_O(b_out), .PB_OE_O(b_oe), .PB_PULLUP_O(b_pu),
    .PC_PIN_I(c_pin), .PC_OUT_O(c_out), .PC_OE_O(c_oe), .PC_PULLUP_O(c_pu),
    .PD_PIN_I(d_pin), .PD_OUT_O(d_out), .PD_OE_O(d_oe), .PD_PULLUP_O(d_pu),
    .SLEEP_EXEC_I(slp), .EXEC_IN_BOOT_I(boot), .APP_LOCK_BIT_I(alck), .BOOT_LOCK_BIT_I(blck),
    .INSTR_DONE_I(idone), .VECTOR_IN_BOOT_O(vec), .IRQ_BLOCK_O(blk), .BROWNOUT_SLEEP_OFF_O(bso),
    .DETECTOR_OFF_IN_SLEEP_O(bis)
  );
  task automatic finish_test();
    if (err_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  // One access per call, strobe held for exactly one edge
  task automatic acc(input bit io, input bit w, input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    dwr = w && !io;
    iwr = w && io;
    drd = !w && !io;
    ird = !w && io;
    addr = io ? a - 8'h20 : a;
    wdata = d;
    cyc(1);
    {dwr, iwr, drd, ird} = 4'h0;
  endtask : acc
  task automatic wr(input bit io, input logic [7:0] a, input logic [7:0] d);
    acc(io, 1'b1, a, d);
  endtask : wr
  task automatic rd(input bit io, input logic [7:0] a, input logic [7:0] e, input logic h);
    acc(io, 1'b0, a, 8'h00);
    chk(rdata, e);
    chk(8'(hit), 8'(h));
  endtask : rd
  task automatic pulse(ref logic s);
    cyc(1);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask : pulse
  // ****************
  // Scenarios
  // ****************
  initial begin
    cyc(20);
    rst_n = 1'b1;
    for (int i = 0; i < 7; i++) rd(i[0], regs[i], 8'h00, 1'b1);
    for (int i = 0; i < 6; i++) begin
      wr(i[0], regs[i], 8'hA5);
      rd(!i[0], regs[i], (i == 2 || i == 3) ? 8'h25 : 8'hA5, 1'b1);
    end
    chk(d_oe, 8'hA5);
    chk(d_out, 8'hA5);
    chk(d_pu, 8'h00);
    rd(1'b0, 8'h29, 8'h00, 1'b0);
    rd(1'b1, 8'h3F, 8'h00, 1'b0);
    wr(1'b1, 8'h55, 8'h9C);
    rd(1'b0, 8'h55, 8'h10, 1'b1);
    wr(1'b0, 8'h24, 8'h0F);
    rd(1'b0, 8'h24, 8'h0F, 1'b1);
    wr(1'b0, 8'h25, 8'h3C);
    cyc(4);
    chk(b_pu, 8'h00);
    rd(1'b1, 8'h23, 8'h8C, 1'b1);
    wr(1'b1, 8'h55, 8'h00);
    cyc(4);
    chk(b_pu, 8'h30);
    chk(b_out & b_oe, 8'h0C);
    rd(1'b0, 8'h23, 8'hBC, 1'b1);
    wr(1'b0, 8'h23, 8'h0F);
    rd(1'b1, 8'h25, 8'h33, 1'b1);
    wr(1'b1, 8'h26, 8'hFF);
    rd(1'b0, 8'h28, 8'h5A, 1'b1);
    rd(1'b0, 8'h26, 8'h5A, 1'b1);
    chk(8'(c_pu), 8'h5A);
    chk(8'(c_oe | c_out), 8'h25);
    wr(1'b0, 8'h55, 8'h01);
    chk(blk, 1'b1);
    wr(1'b1, 8'h55, 8'h02);
    cyc(1);
    chk(vec, 1'b1);
    chk(blk, 1'b1);
    pulse(idone);
    cyc(1);
    chk(blk, 1'b0);
    rd(1'b0, 8'h55, 8'h02, 1'b1);
    wr(1'b0, 8'h55, 8'h00);
    cyc(1);
    chk(vec, 1'b1);
    wr(1'b0, 8'h55, 8'h03);
    cyc(3);
    chk(blk, 1'b1);
    cyc(1);
    chk(blk, 1'b0);
    rd(1'b1, 8'h55, 8'h02, 1'b1);
    alck = 1'b1;
    cyc(2);
    chk(blk, 1'b1);
    boot = 1'b1;
    cyc(2);
    chk(blk, 1'b0);
    wr(1'b0, 8'h55, 8'h01);
    wr(1'b0, 8'h55, 8'h00);
    pulse(idone);
    cyc(1);
    chk(vec, 1'b0);
    blck = 1'b1;
    cyc(2);
    chk(blk, 1'b1);
    boot = 1'b0;
    cyc(2);
    chk(blk, 1'b0);
    pulse(slp);
    chk(bis, 1'b0);
    wr(1'b0, 8'h55, 8'h60);
    wr(1'b0, 8'h55, 8'h40);
    n = 0;
    while (bso !== 1'b1 && n < 8) begin
      cyc(1);
      n++;
    end
    chk(bso, 1'b1);
    chk(8'(n), 8'h03);
    pulse(slp);
    chk(bis, 1'b1);
    cyc(1);
    chk(bso, 1'b0);
    wr(1'b0, 8'h55, 8'h60);
    cyc(6);
    wr(1'b0, 8'h55, 8'h40);
    cyc(4);
    chk(bso, 1'b0);
    finish_test();
  end
  // Sequence needs under two hundred cycles; 2500 cycles marks a hang
  initial begin
    #100000;
    err_count++;
    finish_test();
  end
endmodule : tb_io_port_and_mcu_control_regs

/* design/gpc_io_ctrl.sv */
`include "gpc_consts.svh"
module gpc_io_ctrl
  import gpc_pkg::*;
#(
  parameter int B_WIDTH = 8,
  parameter int C_WIDTH = 7,
  parameter int D_WIDTH = 8
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic DATA_WR_I,
  input wire logic DATA_RD_I,
  input wire logic IO_WR_I,
  input wire logic IO_RD_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  output logic [7:0] RDATA_O,
  output logic HIT_O,
  input wire logic [B_WIDTH-1:0] PB_PIN_I,
  output logic [B_WIDTH-1:0] PB_OUT_O,
  output logic [B_WIDTH-1:0] PB_OE_O,
  output logic [B_WIDTH-1:0] PB_PULLUP_O,
  input wire logic [C_WIDTH-1:0] PC_PIN_I,
  output logic [C_WIDTH-1:0] PC_OUT_O,
  output logic [C_WIDTH-1:0] PC_OE_O,
  output logic [C_WIDTH-1:0] PC_PULLUP_O,
  input wire logic [D_WIDTH-1:0] PD_PIN_I,
  output logic [D_WIDTH-1:0] PD_OUT_O,
  output logic [D_WIDTH-1:0] PD_OE_O,
  output logic [D_WIDTH-1:0] PD_PULLUP_O,
  input wire logic SLEEP_EXEC_I,
  input wire logic EXEC_IN_BOOT_I,
  input wire logic APP_LOCK_BIT_I,
  input wire logic BOOT_LOCK_BIT_I,
  input wire logic INSTR_DONE_I,
  output logic VECTOR_IN_BOOT_O,
  output logic IRQ_BLOCK_O,
  output logic BROWNOUT_SLEEP_OFF_O,
  output logic DETECTOR_OFF_IN_SLEEP_O
);

  // ************************************************************
  // Parameter checks
  // ************************************************************
  // Decode and field masks assume the fixed port widths
  if (B_WIDTH != 8 || C_WIDTH != 7 || D_WIDTH != 8) begin : g_bad_widths
    $error("gpc_io_ctrl: port widths are fixed at 8/7/8");
  end

  // ************************************************************
  // Address decode
  // ************************************************************
  logic wr;
  logic rd;
  logic [7:0] off;
  gpc_byte_t wdata;

  assign wr = DATA_WR_I | IO_WR_I;
  assign rd = DATA_RD_I | IO_RD_I;
  assign wdata = WDATA_I;

  always_comb begin
    off = ADDR_I;
    if (IO_WR_I || IO_RD_I) begin
      off = {2'b00, ADDR_I[5:0]} + `GPC_IO_BASE;
    end
  end

  logic sel_b_in, sel_b_dir, sel_b_out, sel_c_in, sel_c_dir, sel_c_out, sel_d_dir, sel_d_out, sel_ctrl;
  assign sel_b_in = (off == `GPC_OFF_B_IN);
  assign sel_b_dir = (off == `GPC_OFF_B_DIR);
  assign sel_b_out = (off == `GPC_OFF_B_OUT);
  assign sel_c_in = (off == `GPC_OFF_C_IN);
  assign sel_c_dir = (off == `GPC_OFF_C_DIR);
  assign sel_c_out = (off == `GPC_OFF_C_OUT);
  assign sel_d_dir = (off == `GPC_OFF_D_DIR);
  assign sel_d_out = (off == `GPC_OFF_D_OUT);
  assign sel_ctrl = (off == `GPC_OFF_CTRL);

  // ************************************************************
  // Ports
  // ************************************************************
  gpc_port_if #(.WIDTH(B_WIDTH)) pb_if ();
  gpc_port_if #(.WIDTH(C_WIDTH)) pc_if ();
  gpc_port_if #(.WIDTH(D_WIDTH)) pd_if ();

  logic [7:0] ctrl_q;
  logic pud_q;
  logic vsel_q;
  logic pullup_off;
  assign pullup_off = pud_q;

  assign pb_if.wr_dir = wr & sel_b_dir;
  assign pb_if.wr_out = wr & sel_b_out;
  assign pb_if.wr_tog = wr & sel_b_in;
  assign pb_if.wdata = wdata[B_WIDTH-1:0];
  assign pb_if.pullup_off = pullup_off;
  assign pc_if.wr_dir = wr & sel_c_dir;
  assign pc_if.wr_out = wr & sel_c_out;
  assign pc_if.wr_tog = wr & sel_c_in;
  assign pc_if.wdata = wdata[C_WIDTH-1:0];
  assign pc_if.pullup_off = pullup_off;
  // Port D input register lives outside this bank; no toggle path here
  assign pd_if.wr_dir = wr & sel_d_dir;
  assign pd_if.wr_out = wr & sel_d_out;
  assign pd_if.wr_tog = 1'b0;
  assign pd_if.wdata = wdata[D_WIDTH-1:0];
  assign pd_if.pullup_off = pullup_off;

  gpc_port #(.WIDTH(B_WIDTH)) u_pb (.clk_i(CLK_SYS_I), .rst_n_i(RST_N_I), .pin_i(PB_PIN_I), .bus(pb_if.port));
  gpc_port #(.WIDTH(C_WIDTH)) u_pc (.clk_i(CLK_SYS_I), .rst_n_i(RST_N_I), .pin_i(PC_PIN_I), .bus(pc_if.port));
  gpc_port #(.WIDTH(D_WIDTH)) u_pd (.clk_i(CLK_SYS_I), .rst_n_i(RST_N_I), .pin_i(PD_PIN_I), .bus(pd_if.port));

  assign PB_OUT_O = pb_if.pad_out;
  assign PB_OE_O = pb_if.pad_oe;
  assign PB_PULLUP_O = pb_if.pad_pullup;
  assign PC_OUT_O = pc_if.pad_out;
  assign PC_OE_O = pc_if.pad_oe;
  assign PC_PULLUP_O = pc_if.pad_pullup;
  assign PD_OUT_O = pd_if.pad_out;
  assign PD_OE_O = pd_if.pad_oe;
  assign PD_PULLUP_O = pd_if.pad_pullup;

  // ************************************************************
  // Control register: pull-up and vector select
  // ************************************************************
  logic ctrl_wr;
  logic [2:0] unlock_cnt_q;
  logic vec_unlock_q;
  logic sel_written;
  assign ctrl_wr = wr & sel_ctrl;
  assign sel_written = ctrl_wr & vec_unlock_q & ~wdata[`GPC_BIT_VEC_UNLOCK];

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      pud_q <= 1'b0;
    end else if (ctrl_wr) begin
      pud_q <= wdata[`GPC_BIT_PULLUP_OFF];
    end
  end

  // Select only changes inside the unlock window; stray writes leave it alone
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      vsel_q <= 1'b0;
    end else if (sel_written) begin
      vsel_q <= wdata[`GPC_BIT_VEC_SEL];
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      vec_unlock_q <= 1'b0;
      unlock_cnt_q <= 3'd0;
    end else if (ctrl_wr && wdata[`GPC_BIT_VEC_UNLOCK]) begin
      vec_unlock_q <= 1'b1;
      unlock_cnt_q <= `GPC_UNLOCK_CYCLES - 3'd1;
    end else if (sel_written || unlock_cnt_q == 3'd0) begin
      vec_unlock_q <= 1'b0;
      unlock_cnt_q <= 3'd0;
    end else begin
      unlock_cnt_q <= unlock_cnt_q - 3'd1;
    end
  end

  // ************************************************************
  // Interrupt blocking
  // ************************************************************
  // Blocking holds until the instruction after the select write completes
  logic post_sel_q;
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      post_sel_q <= 1'b0;
    end else if (sel_written) begin
      post_sel_q <= 1'b1;
    end else if (INSTR_DONE_I) begin
      post_sel_q <= 1'b0;
    end
  end

  // ************************************************************
  // Brown-out sleep-off timed sequence
  // ************************************************************
  gpc_sleep_e so_q;
  logic [2:0] so_cnt_q;
  logic [2:0] so_unlock_cnt_q;
  logic so_unlock_q;
  logic arm;

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      so_unlock_q <= 1'b0;
      so_unlock_cnt_q <= 3'd0;
    end else if (ctrl_wr && wdata[`GPC_BIT_SLEEP_OFF] && wdata[`GPC_BIT_SLEEP_UNLOCK]) begin
      so_unlock_q <= 1'b1;
      so_unlock_cnt_q <= `GPC_UNLOCK_CYCLES - 3'd1;
    end else if (arm || so_unlock_cnt_q == 3'd0) begin
      so_unlock_q <= 1'b0;
      so_unlock_cnt_q <= 3'd0;
    end else begin
      so_unlock_cnt_q <= so_unlock_cnt_q - 3'd1;
    end
  end
  assign arm = ctrl_wr & so_unlock_q & wdata[`GPC_BIT_SLEEP_OFF] & ~wdata[`GPC_BIT_SLEEP_UNLOCK];

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      so_q <= GPC_SO_IDLE;
      so_cnt_q <= 3'd0;
    end else begin
      unique case (so_q)
        GPC_SO_IDLE: begin
          if (arm) begin
            so_q <= GPC_SO_WAIT;
            so_cnt_q <= `GPC_SLEEP_DELAY - 3'd1;
          end
        end
        GPC_SO_WAIT: begin
          if (so_cnt_q == 3'd0) begin
            so_q <= GPC_SO_ACTIVE;
            so_cnt_q <= `GPC_SLEEP_HOLD - 3'd1;
          end else begin
            so_cnt_q <= so_cnt_q - 3'd1;
          end
        end
        GPC_SO_ACTIVE: begin
          if (so_cnt_q == 3'd0) begin
            so_q <= GPC_SO_IDLE;
          end else begin
            so_cnt_q <= so_cnt_q - 3'd1;
          end
        end
        default: begin
          so_q <= GPC_SO_IDLE;
        end
      endcase
    end
  end
  // Bit reads set from the arming write so software sees it accepted
  // Holes at bits 7, 3 and 2 keep the reset value and read as zero
  always_comb begin
    ctrl_q = `GPC_RST_CTRL;
    ctrl_q[`GPC_BIT_SLEEP_OFF] = (so_q != GPC_SO_IDLE);
    ctrl_q[`GPC_BIT_SLEEP_UNLOCK] = so_unlock_q;
    ctrl_q[`GPC_BIT_PULLUP_OFF] = pud_q;
    ctrl_q[`GPC_BIT_VEC_SEL] = vsel_q;
    ctrl_q[`GPC_BIT_VEC_UNLOCK] = vec_unlock_q;
  end

  // Registered pulse: next value is high from the last wait cycle, so it shows three cycles after arming
  logic sleep_off_d;
  assign sleep_off_d = ((so_q == GPC_SO_WAIT) && (so_cnt_q == 3'd0)) ||
    ((so_q == GPC_SO_ACTIVE) && (so_cnt_q != 3'd0));

  // ************************************************************
  // Core-facing outputs
  // ************************************************************
  logic irq_block_d;
  logic lock_block;
  assign lock_block = (ctrl_q[`GPC_BIT_VEC_SEL] & APP_LOCK_BIT_I & ~EXEC_IN_BOOT_I) |
    (~ctrl_q[`GPC_BIT_VEC_SEL] & BOOT_LOCK_BIT_I & EXEC_IN_BOOT_I);
  // Last unlock cycle left out: the registered block then ends four cycles after the unlock write
  assign irq_block_d = (ctrl_wr & wdata[`GPC_BIT_VEC_UNLOCK]) | (vec_unlock_q & (unlock_cnt_q != 3'd0)) |
    post_sel_q | sel_written | lock_block;

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      IRQ_BLOCK_O <= 1'b0;
    end else begin
      IRQ_BLOCK_O <= irq_block_d;
    end
  end

  // Follows the select write in the same edge so fetch sees the new table at once
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      VECTOR_IN_BOOT_O <= 1'b0;
    end else begin
      VECTOR_IN_BOOT_O <= sel_written ? wdata[`GPC_BIT_VEC_SEL] : ctrl_q[`GPC_BIT_VEC_SEL];
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      BROWNOUT_SLEEP_OFF_O <= 1'b0;
    end else begin
      BROWNOUT_SLEEP_OFF_O <= sleep_off_d;
    end
  end

  // ************************************************************
  // Sleep entry
  // ************************************************************
  // Decision is latched per sleep; it holds until the next sleep instruction
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      DETECTOR_OFF_IN_SLEEP_O <= 1'b0;
    end else if (SLEEP_EXEC_I) begin
      DETECTOR_OFF_IN_SLEEP_O <= (so_q == GPC_SO_ACTIVE);
    end
  end

  // ************************************************************
  // Read data
  // ************************************************************
  gpc_byte_t rdata_d;
  always_comb begin
    rdata_d = 8'h00;
    if (sel_b_in) rdata_d = 8'(pb_if.pin_level);
    if (sel_b_dir) rdata_d = 8'(pb_if.dir);
    if (sel_b_out) rdata_d = 8'(pb_if.out);
    if (sel_c_in) rdata_d = 8'(pc_if.pin_level);
    if (sel_c_dir) rdata_d = 8'(pc_if.dir);
    if (sel_c_out) rdata_d = 8'(pc_if.out);
    if (sel_d_dir) rdata_d = 8'(pd_if.dir);
    if (sel_d_out) rdata_d = 8'(pd_if.out);
    if (sel_ctrl) rdata_d = ctrl_q & `GPC_CTRL_MASK;
  end

  logic hit;
  assign hit = sel_b_in | sel_b_dir | sel_b_out | sel_c_in | sel_c_dir | sel_c_out | sel_d_dir | sel_d_out |
    sel_ctrl;

  // Idle cycles return zero so a shared read bus can be ORed
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      RDATA_O <= 8'h00;
    end else begin
      RDATA_O <= rd ? rdata_d : 8'h00;
    end
  end

  // Writes report a hit too, so the core can tell a dead address
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      HIT_O <= 1'b0;
    end else begin
      HIT_O <= (rd | wr) & hit;
    end
  end
endmodule : gpc_io_ctrl

/* design/gpc_port.sv */
`include "gpc_consts.svh"
module gpc_port #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] pin_i,
  gpc_port_if.port bus
);
  logic [WIDTH-1:0] dir_q;
  logic [WIDTH-1:0] out_q;
  logic [WIDTH-1:0] sync1_q;
  logic [WIDTH-1:0] sync2_q;
  logic [WIDTH-1:0] pad_out_q;
  logic [WIDTH-1:0] pad_oe_q;
  logic [WIDTH-1:0] pad_pu_q;

  if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
    $error("gpc_port: WIDTH must be 1..8");
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dir_q <= WIDTH'(`GPC_RST_PORT);
    end else if (bus.wr_dir) begin
      dir_q <= bus.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      out_q <= WIDTH'(`GPC_RST_PORT);
    end else if (bus.wr_tog) begin
      out_q <= out_q ^ bus.wdata;
    end else if (bus.wr_out) begin
      out_q <= bus.wdata;
    end
  end

  // No reset: levels follow the pins
  always_ff @(posedge clk_i) begin
    sync1_q <= pin_i;
    sync2_q <= sync1_q;
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_pad
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          pad_out_q[g] <= 1'b0;
          pad_oe_q[g] <= 1'b0;
          pad_pu_q[g] <= 1'b0;
        end else begin
          pad_oe_q[g] <= dir_q[g];
          pad_out_q[g] <= out_q[g] & dir_q[g];
          pad_pu_q[g] <= ~dir_q[g] & out_q[g] & ~bus.pullup_off;
        end
      end
    end
  endgenerate

  assign bus.dir = dir_q;
  assign bus.out = out_q;
  assign bus.pin_level = sync2_q;
  assign bus.pad_out = pad_out_q;
  assign bus.pad_oe = pad_oe_q;
  assign bus.pad_pullup = pad_pu_q;
endmodule : gpc_port

/* pkg/gpc_consts.svh */
`ifndef GPC_CONSTS_SVH
`define GPC_CONSTS_SVH
`define GPC_IO_BASE 8'h20
`define GPC_OFF_B_IN 8'h23
`define GPC_OFF_B_DIR 8'h24
`define GPC_OFF_B_OUT 8'h25
`define GPC_OFF_C_IN 8'h26
`define GPC_OFF_C_DIR 8'h27
`define GPC_OFF_C_OUT 8'h28
`define GPC_OFF_D_DIR 8'h2A
`define GPC_OFF_D_OUT 8'h2B
`define GPC_OFF_CTRL 8'h55
`define GPC_RST_PORT 8'h00
`define GPC_RST_CTRL 8'h00
`define GPC_CTRL_MASK 8'h73
`define GPC_BIT_SLEEP_OFF 6
`define GPC_BIT_SLEEP_UNLOCK 5
`define GPC_BIT_PULLUP_OFF 4
`define GPC_BIT_VEC_SEL 1
`define GPC_BIT_VEC_UNLOCK 0
`define GPC_UNLOCK_CYCLES 3'd4
`define GPC_SLEEP_DELAY 3'd3
`define GPC_SLEEP_HOLD 3'd3
`endif

/* pkg/gpc_pkg.sv */
package gpc_pkg;
  typedef logic [7:0] gpc_byte_t;
  typedef enum logic [2:0] {
    GPC_SO_IDLE = 3'b001,
    GPC_SO_WAIT = 3'b010,
    GPC_SO_ACTIVE = 3'b100
  } gpc_sleep_e;
endpackage : gpc_pkg

/* pkg/gpc_port_if.sv */
interface gpc_port_if #(parameter int WIDTH = 8);
  logic wr_dir;
  logic wr_out;
  logic wr_tog;
  logic [WIDTH-1:0] wdata;
  logic pullup_off;
  logic [WIDTH-1:0] dir;
  logic [WIDTH-1:0] out;
  logic [WIDTH-1:0] pin_level;
  logic [WIDTH-1:0] pad_out;
  logic [WIDTH-1:0] pad_oe;
  logic [WIDTH-1:0] pad_pullup;
  modport ctrl (output wr_dir, wr_out, wr_tog, wdata, pullup_off, input dir, out, pin_level);
  modport port (input wr_dir, wr_out, wr_tog, wdata, pullup_off, output dir, out, pin_level,
    pad_out, pad_oe, pad_pullup);
endinterface : gpc_port_if
